// [design/eep_ctrl.sv]
/*
  EEPROM program/erase controller: control register, target latch, high
  voltage gating and the setup byte shadow latches.
  Assumes the CPU bus issues one-cycle read and write strobes on the core
  clock and that the array and charge pump sit outside and obey the O_ARR
  outputs. The setup byte cells are presented on I_SETUP_CELLS at reset.
*/
// Summary of operation
// R1: Array writes ignored while high voltage set.
// R2: Cycle in progress blocks other location writes.
// R3: Both test bits program half-array rows.
// R4: Control bit 5 reads zero.
// R5: Byte/row bits decode bulk, row, byte.
// R6: Byte select bit always read/writable.
// R7: Row and erase bits always read/writable.
// R8: Latch bit captures writes; clear reads ROM.
// R9: Protection never affects array reads.
// R10: High voltage writable only with latch set.
// R11: Latch clear forces high voltage clear.
// R12: Program ignores row and byte bits.
// R13: Software sets oscillator select below 1MHz.
// R14: Software erases before programming.
// R15: Program sequence 0x02, store, 0x03, clear.
// R16: Erase: setup, write in scope, voltage.
// R17: Row/bulk erase triggered by any write.
// R18: Byte erase touches only addressed byte.
// R19: Software clears voltage, then register.
// R20: Setup byte programmable unless protect set.
// R21: Setup reads show latches from reset.
// R22: ROM enable writable per mode bits.
`timescale 1ns/100ps
`default_nettype none
module eep_ctrl (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // CPU bus
  input wire logic [15:0] I_BUS_ADDR,
  input wire logic [7:0] I_BUS_WDATA,
  input wire logic I_BUS_WR,
  input wire logic I_BUS_RD,
  output logic [7:0] O_BUS_RDATA,
  output logic O_BUS_RVALID,
  output logic O_WR_BLOCKED,
  // Mapping, modes and protection
  input wire logic [3:0] I_EE_PAGE,
  input wire logic I_MODE_BIT_A,
  input wire logic I_SPECIAL_MODE,
  input wire logic I_ROM_OPTION,
  input wire logic [3:0] I_BLOCK_PROTECT,
  input wire logic I_SETUP_PROTECT,
  // Array side
  input wire logic [7:0] I_ARR_RDATA,
  input wire logic [7:0] I_SETUP_CELLS,
  output logic [9:0] O_ARR_ADDR,
  output logic [7:0] O_ARR_WDATA,
  output logic O_ARR_SEL_SETUP,
  output logic O_ARR_ERASE,
  output logic [3:0] O_ARR_SCOPE,
  output logic O_ARR_HV,
  output logic O_ARR_PROG_BUS,
  // Active setup byte
  output logic [7:0] O_SETUP_ACTIVE
);

  // ********************************************************************
  // State
  // ********************************************************************
  logic [7:0] ctrl_q, ctrl_d;
  eep_pkg::eep_state_t state_q, state_d;
  logic [9:0] lat_addr_q, lat_addr_d;
  logic lat_setup_q, lat_setup_d;
  logic [7:0] lat_data_q, lat_data_d;
  logic [7:0] setup_q, setup_d;
  logic load_q;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic blocked_q, blocked_d;
  logic hv_out_q, hv_out_d;
  logic [3:0] scope_q;
  logic direct_wr;

  // ********************************************************************
  // Address decode
  // ********************************************************************
  logic [11:0] rel_addr;
  logic in_array, is_ctrl, is_setup, wr_target, same_target;
  logic single_chip, bootstrap, rom_wr_ok;
  logic [7:0] setup_view;
  eep_pkg::eep_scope_t scope;
  logic prot;

  assign rel_addr = I_BUS_ADDR[11:0] - eep_pkg::ARRAY_START;
  assign in_array = (I_BUS_ADDR[15:12] == I_EE_PAGE) &&
                    (I_BUS_ADDR[11:0] >= eep_pkg::ARRAY_START);
  assign is_ctrl = (I_BUS_ADDR == eep_pkg::ADDR_PROG_CTRL);
  assign is_setup = (I_BUS_ADDR == eep_pkg::ADDR_SETUP);
  assign wr_target = I_BUS_WR && (in_array || is_setup) && ctrl_q[eep_pkg::BIT_LATCH]; // R8
  assign same_target = (is_setup == lat_setup_q) &&
                       (is_setup || (rel_addr[9:0] == lat_addr_q));
  assign single_chip = !I_SPECIAL_MODE && !I_MODE_BIT_A;
  assign bootstrap = I_SPECIAL_MODE && !I_MODE_BIT_A;
  assign rom_wr_ok = I_ROM_OPTION && I_MODE_BIT_A && !bootstrap;
  assign direct_wr = I_BUS_WR && is_setup && !ctrl_q[eep_pkg::BIT_LATCH];

  always_comb
  begin
    setup_view = setup_q;
    if (I_ROM_OPTION && single_chip)
      setup_view[eep_pkg::BIT_ROM_EN] = 1'b1; // R22
  end

  eep_scope u_scope (
    .i_offset(lat_addr_q),
    .i_is_setup(lat_setup_q),
    .i_ctrl(ctrl_q),
    .i_block_protect(I_BLOCK_PROTECT),
    .i_setup_protect(I_SETUP_PROTECT),
    .o_scope(scope),
    .o_protected(prot)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    lat_addr_d = lat_addr_q;
    lat_setup_d = lat_setup_q;
    lat_data_d = lat_data_q;
    setup_d = setup_q;
    blocked_d = 1'b0;
    rvalid_d = 1'b0;
    rdata_d = 8'h00;
    if (load_q)
      setup_d = I_SETUP_CELLS; // R21
    if (I_BUS_WR && is_ctrl)
    begin
      // Byte, row and erase bits take any write; bit 5 is dropped.
      ctrl_d = I_BUS_WDATA & eep_pkg::PROG_CTRL_WMASK; // R4 R6 R7
      if (!ctrl_q[eep_pkg::BIT_LATCH])
        ctrl_d[eep_pkg::BIT_HV] = ctrl_q[eep_pkg::BIT_HV]; // R10
      if (!ctrl_d[eep_pkg::BIT_LATCH])
        ctrl_d[eep_pkg::BIT_HV] = 1'b0; // R11
    end
    if (wr_target)
    begin
      if (ctrl_q[eep_pkg::BIT_HV])
        blocked_d = 1'b1; // R1
      else if (state_q == eep_pkg::ST_IDLE)
      begin
        lat_addr_d = is_setup ? 10'h000 : rel_addr[9:0];
        lat_setup_d = is_setup; // R20
        lat_data_d = I_BUS_WDATA;
      end
      else if (same_target)
        lat_data_d = I_BUS_WDATA;
      else
        blocked_d = 1'b1; // R2
    end
    case (state_q)
      eep_pkg::ST_IDLE:
      begin
        if (wr_target && !ctrl_q[eep_pkg::BIT_HV])
          state_d = eep_pkg::ST_LATCHED;
      end
      eep_pkg::ST_LATCHED:
      begin
        if (ctrl_q[eep_pkg::BIT_HV])
          state_d = eep_pkg::ST_HV;
      end
      eep_pkg::ST_HV:
      begin
        if (!ctrl_q[eep_pkg::BIT_HV])
          state_d = eep_pkg::ST_LATCHED;
      end
      default:
        state_d = eep_pkg::ST_IDLE;
    endcase
    // Dropping the latch bit abandons any captured target.
    if (!ctrl_q[eep_pkg::BIT_LATCH])
      state_d = eep_pkg::ST_IDLE; // R8
    if (direct_wr)
    begin
      if (rom_wr_ok)
        setup_d[eep_pkg::BIT_ROM_EN] = I_BUS_WDATA[eep_pkg::BIT_ROM_EN]; // R22
      if (I_SPECIAL_MODE)
      begin
        setup_d = I_BUS_WDATA;
        if (!rom_wr_ok)
          setup_d[eep_pkg::BIT_ROM_EN] = setup_q[eep_pkg::BIT_ROM_EN]; // R22
      end
    end
    if (I_BUS_RD)
    begin
      rvalid_d = is_ctrl || is_setup || in_array;
      if (is_ctrl)
        rdata_d = ctrl_q;
      else if (is_setup)
        rdata_d = setup_view; // R21
      else if (in_array)
        // Protection plays no part here; only the latch bit hides the array.
        rdata_d = ctrl_q[eep_pkg::BIT_LATCH] ? eep_pkg::LOCKED_READ : I_ARR_RDATA; // R8 R9
    end
    hv_out_d = (state_q == eep_pkg::ST_HV) && ctrl_q[eep_pkg::BIT_HV] && !prot; // R20
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      ctrl_q <= eep_pkg::PROG_CTRL_RESET;
      state_q <= eep_pkg::ST_IDLE;
      lat_addr_q <= 10'h000;
      lat_setup_q <= 1'b0;
      lat_data_q <= 8'h00;
      setup_q <= eep_pkg::SETUP_RESET;
      load_q <= 1'b1;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      blocked_q <= 1'b0;
      hv_out_q <= 1'b0;
      scope_q <= eep_pkg::SC_BYTE;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      lat_addr_q <= lat_addr_d;
      lat_setup_q <= lat_setup_d;
      lat_data_q <= lat_data_d;
      setup_q <= setup_d;
      load_q <= 1'b0;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      blocked_q <= blocked_d;
      hv_out_q <= hv_out_d;
      scope_q <= scope;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // The setup byte output mirrors the forced view so that, once out of reset (which loads
  // SETUP_RESET), the core never sees a ROM disable in single-chip mode with I_ROM_OPTION set.
  logic [7:0] setup_out_q;
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
      setup_out_q <= eep_pkg::SETUP_RESET;
    else
      setup_out_q <= setup_view;
  end

  assign O_BUS_RDATA = rdata_q;
  assign O_BUS_RVALID = rvalid_q;
  assign O_WR_BLOCKED = blocked_q;
  assign O_ARR_ADDR = lat_addr_q;
  assign O_ARR_WDATA = lat_data_q;
  assign O_ARR_SEL_SETUP = lat_setup_q;
  assign O_ARR_ERASE = ctrl_q[eep_pkg::BIT_ERASE];
  assign O_ARR_SCOPE = scope_q;
  assign O_ARR_HV = hv_out_q;
  assign O_ARR_PROG_BUS = ctrl_q[eep_pkg::BIT_LATCH];
  assign O_SETUP_ACTIVE = setup_out_q;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  property p_hv_ignore;
    wr_target && ctrl_q[eep_pkg::BIT_HV] |=> $stable(lat_data_q) && O_WR_BLOCKED;
  endproperty
  a_hv_ignore: assert property (p_hv_ignore) else $error("write taken under high voltage"); // R1

  property p_other_blocked;
    wr_target && !ctrl_q[eep_pkg::BIT_HV] && state_q != eep_pkg::ST_IDLE && !same_target
      |=> $stable(lat_addr_q) && $stable(lat_data_q);
  endproperty
  a_other_blocked: assert property (p_other_blocked) else $error("second location taken"); // R2

  property p_half;
    ctrl_q[eep_pkg::BIT_ODD] && ctrl_q[eep_pkg::BIT_EVEN] && !ctrl_q[eep_pkg::BIT_ERASE]
      |=> O_ARR_SCOPE == eep_pkg::SC_HALF;
  endproperty
  a_half: assert property (p_half) else $error("half-array scope missing"); // R3

  property p_bit5;
    I_BUS_RD && is_ctrl |=> O_BUS_RVALID && !O_BUS_RDATA[eep_pkg::BIT_UNUSED];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bit 5 read as one"); // R4

  property p_bulk;
    ctrl_q[eep_pkg::BIT_ERASE] && !ctrl_q[eep_pkg::BIT_BYTE] && !ctrl_q[eep_pkg::BIT_ROW]
      |=> O_ARR_SCOPE == eep_pkg::SC_BULK;
  endproperty
  a_bulk: assert property (p_bulk) else $error("bulk scope missing"); // R5

  property p_rom_read;
    I_BUS_RD && in_array && !is_ctrl && !is_setup && !ctrl_q[eep_pkg::BIT_LATCH]
      |=> O_BUS_RDATA == $past(I_ARR_RDATA);
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("array read not passed"); // R8 R9

  property p_hv_gate;
    I_BUS_WR && is_ctrl && !ctrl_q[eep_pkg::BIT_LATCH] && !ctrl_q[eep_pkg::BIT_HV]
      |=> !ctrl_q[eep_pkg::BIT_HV] ##1 !O_ARR_HV;
  endproperty
  a_hv_gate: assert property (p_hv_gate) else $error("voltage set without latch"); // R10

  property p_latch_off;
    !ctrl_q[eep_pkg::BIT_LATCH] |-> !ctrl_q[eep_pkg::BIT_HV] ##1 state_q == eep_pkg::ST_IDLE;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("voltage kept with latch clear"); // R11

  property p_setup_prot;
    lat_setup_q && I_SETUP_PROTECT |=> !O_ARR_HV;
  endproperty
  a_setup_prot: assert property (p_setup_prot) else $error("protected setup byte driven"); // R20

  property p_setup_static;
    !load_q && !direct_wr |=> $stable(setup_q);
  endproperty
  a_setup_static: assert property (p_setup_static) else $error("setup latch changed"); // R21

  c_program: cover property (state_q == eep_pkg::ST_HV && !ctrl_q[eep_pkg::BIT_ERASE]);
  c_bulk: cover property (O_ARR_HV && O_ARR_SCOPE == eep_pkg::SC_BULK);
  c_setup_wr: cover property (direct_wr && I_SPECIAL_MODE);
  c_blocked: cover property (O_WR_BLOCKED);

endmodule
`default_nettype wire

// [design/eep_pkg.sv]
/*
  Constants and types shared by the EEPROM program/erase controller files.
  Assumes an 8-bit CPU data bus with 16-bit byte addresses.
*/
package eep_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [15:0] ADDR_PROG_CTRL = 16'h003B;
  localparam logic [15:0] ADDR_SETUP = 16'h003F;
  localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
  localparam logic [7:0] PROG_CTRL_WMASK = 8'hDF;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] LOCKED_READ = 8'hFF;

  // ********************************************************************
  // Control register fields and setup byte ROM enable bit
  // ********************************************************************
  localparam int BIT_ODD = 7;
  localparam int BIT_EVEN = 6;
  localparam int BIT_UNUSED = 5;
  localparam int BIT_BYTE = 4;
  localparam int BIT_ROW = 3;
  localparam int BIT_ERASE = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_HV = 0;
  localparam int BIT_ROM_EN = 1;

  // ********************************************************************
  // Array geometry
  // ********************************************************************
  localparam logic [11:0] ARRAY_START = 12'hD00;
  localparam logic [9:0] BLOCK_BYTES = 10'h0C0;
  localparam int PROT_BLOCKS = 4;

  typedef enum logic [3:0] {
    SC_BYTE = 4'h1,
    SC_ROW = 4'h2,
    SC_BULK = 4'h4,
    SC_HALF = 4'h8
  } eep_scope_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LATCHED = 3'h2,
    ST_HV = 3'h4
  } eep_state_t;

endpackage

// [design/eep_scope.sv]
/*
  Erase/program scope decoder and protection check for the latched target.
  Assumes the offset is already relative to the array start.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_scope (
  // Latched target
  input wire logic [9:0] i_offset,
  input wire logic i_is_setup,
  // Control bits
  input wire logic [7:0] i_ctrl,
  // Protection
  input wire logic [3:0] i_block_protect,
  input wire logic i_setup_protect,
  // Results
  output eep_pkg::eep_scope_t o_scope,
  output logic o_protected
);

  logic [3:0] blk_hit;

  // ********************************************************************
  // Protection block membership
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < eep_pkg::PROT_BLOCKS; gi++)
    begin : g_blk
      assign blk_hit[gi] = (i_offset >= 10'(gi * eep_pkg::BLOCK_BYTES)) &&
                           (i_offset < 10'((gi + 1) * eep_pkg::BLOCK_BYTES));
    end
  endgenerate

  always_comb
  begin
    if (!i_ctrl[eep_pkg::BIT_ERASE])
    begin
      // Program ignores the erase scope bits; both test bits give a half-array write.
      o_scope = (i_ctrl[eep_pkg::BIT_ODD] && i_ctrl[eep_pkg::BIT_EVEN]) ?
                eep_pkg::SC_HALF : eep_pkg::SC_BYTE; // R12 R3
    end
    else if (i_ctrl[eep_pkg::BIT_BYTE])
      o_scope = eep_pkg::SC_BYTE; // R5 R18
    else if (i_ctrl[eep_pkg::BIT_ROW])
      o_scope = eep_pkg::SC_ROW; // R5 R17
    else
      o_scope = eep_pkg::SC_BULK; // R5 R17
    // A wide operation is refused if any part it touches is protected.
    if (i_is_setup)
      o_protected = i_setup_protect; // R20
    else if (o_scope == eep_pkg::SC_BULK || o_scope == eep_pkg::SC_HALF)
      o_protected = |i_block_protect;
    else
      o_protected = |(blk_hit & i_block_protect);
  end

endmodule
`default_nettype wire

// [verif/eep_arr_model.sv]
/*
  Behavioural EEPROM array and setup byte cells that sit behind eep_ctrl.
  Assumes the controller holds its latched target steady while voltage is applied.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_arr_model (
  // Clock
  input wire logic i_clk,
  // Bus side
  input wire logic [15:0] i_bus_addr,
  output logic [7:0] o_rdata,
  // Controller side
  input wire logic [9:0] i_arr_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_sel_setup,
  input wire logic i_erase,
  input wire logic [3:0] i_scope,
  input wire logic i_hv,
  output logic [7:0] o_cells
);
  logic [7:0] mem [0:767];
  logic [11:0] off;
  logic hv_q = 1'b0;

  initial
  begin
    for (int i = 0; i < 768; i++)
      mem[i] = 8'hFF;
    o_cells = 8'hA5;
  end

  assign off = i_bus_addr[11:0] - 12'hD00;
  // Outside the array no cell drives the bus, so a moving pattern is shown.
  assign o_rdata = (off < 12'h300) ? mem[off] : {8{i_clk}};

  // ****************
  // Cell update
  // ****************
  function automatic logic hit(input int i);
    logic [9:0] a;
    a = 10'(i);
    if (!i_erase || i_scope == eep_pkg::SC_BYTE)
      return a == i_arr_addr;
    if (i_scope == eep_pkg::SC_ROW)
      return a[9:4] == i_arr_addr[9:4];
    return 1'b1;
  endfunction

  // Programming only clears bits, so a byte must be erased first to take new data.
  always @(posedge i_clk)
  begin
    hv_q <= i_hv;
    if (i_hv && !hv_q)
    begin
      if (i_sel_setup)
        o_cells <= i_erase ? 8'hFF : (o_cells & i_wdata);
      else
        for (int i = 0; i < 768; i++)
          if (hit(i))
            mem[i] <= i_erase ? 8'hFF : (mem[i] & i_wdata);
    end
  end
endmodule
`default_nettype wire

// [verif/eep_ctrl_tb.sv]
/*
  Self-checking bench for eep_ctrl: CPU bus tasks and program/erase sequences.
  Assumes eep_arr_model stands in for the array cells and the setup byte cells.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_ctrl_tb;
  localparam logic [15:0] CT = eep_pkg::ADDR_PROG_CTRL;
  localparam logic [15:0] SU = eep_pkg::ADDR_SETUP;
  logic I_CORE_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic [15:0] I_BUS_ADDR = 16'h0000;
  logic [7:0] I_BUS_WDATA = 8'h00;
  logic I_BUS_WR = 1'b0, I_BUS_RD = 1'b0, I_SETUP_PROTECT = 1'b0;
  logic I_MODE_BIT_A = 1'b1, I_SPECIAL_MODE = 1'b0, I_ROM_OPTION = 1'b0;
  logic [3:0] I_EE_PAGE = 4'h0, I_BLOCK_PROTECT = 4'h0, O_ARR_SCOPE;
  logic [7:0] I_ARR_RDATA, I_SETUP_CELLS, O_BUS_RDATA, O_ARR_WDATA, O_SETUP_ACTIVE;
  logic [9:0] O_ARR_ADDR;
  logic O_BUS_RVALID, O_WR_BLOCKED, O_ARR_SEL_SETUP, O_ARR_ERASE, O_ARR_HV, O_ARR_PROG_BUS;
  logic [7:0] sc_ctl [5] = '{8'h06, 8'h0E, 8'h16, 8'h1E, 8'hC2};
  logic [3:0] sc_exp [5] = '{4'h4, 4'h2, 4'h1, 4'h1, 4'h8};
  int fails = 0;
  int checks = 0;

  // The bus clock runs far above 1 MHz, so the oscillator select is never needed.
  always #5 I_CORE_CLK = ~I_CORE_CLK;

  eep_ctrl uut (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_BUS_ADDR(I_BUS_ADDR),
    .I_BUS_WDATA(I_BUS_WDATA), .I_BUS_WR(I_BUS_WR), .I_BUS_RD(I_BUS_RD),
    .O_BUS_RDATA(O_BUS_RDATA), .O_BUS_RVALID(O_BUS_RVALID), .O_WR_BLOCKED(O_WR_BLOCKED),
    .I_EE_PAGE(I_EE_PAGE), .I_MODE_BIT_A(I_MODE_BIT_A), .I_SPECIAL_MODE(I_SPECIAL_MODE),
    .I_ROM_OPTION(I_ROM_OPTION), .I_BLOCK_PROTECT(I_BLOCK_PROTECT),
    .I_SETUP_PROTECT(I_SETUP_PROTECT), .I_ARR_RDATA(I_ARR_RDATA),
    .I_SETUP_CELLS(I_SETUP_CELLS), .O_ARR_ADDR(O_ARR_ADDR), .O_ARR_WDATA(O_ARR_WDATA),
    .O_ARR_SEL_SETUP(O_ARR_SEL_SETUP), .O_ARR_ERASE(O_ARR_ERASE), .O_ARR_SCOPE(O_ARR_SCOPE),
    .O_ARR_HV(O_ARR_HV), .O_ARR_PROG_BUS(O_ARR_PROG_BUS), .O_SETUP_ACTIVE(O_SETUP_ACTIVE)
  );

  eep_arr_model arr (
    .i_clk(I_CORE_CLK), .i_bus_addr(I_BUS_ADDR), .o_rdata(I_ARR_RDATA),
    .i_arr_addr(O_ARR_ADDR), .i_wdata(O_ARR_WDATA), .i_sel_setup(O_ARR_SEL_SETUP),
    .i_erase(O_ARR_ERASE), .i_scope(O_ARR_SCOPE), .i_hv(O_ARR_HV), .o_cells(I_SETUP_CELLS)
  );

  // ****************
  // Tasks
  // ****************
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
    #1;
  endtask

  task automatic rst(input int n);
    I_RESET_N = 1'b0;
    tick(n);
    I_RESET_N = 1'b1;
    tick(3);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick(1);
    I_BUS_ADDR = a;
    I_BUS_WDATA = d;
    I_BUS_WR = 1'b1;
    tick(1);
    I_BUS_WR = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    tick(1);
    I_BUS_ADDR = a;
    I_BUS_RD = 1'b1;
    tick(1);
    I_BUS_RD = 1'b0;
    chk(O_BUS_RVALID, 1'b1);
    chk(O_BUS_RDATA, e);
  endtask

  // Voltage is cleared before the register, so the target stays put until the pump is off.
  task automatic hv_cycle(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c,
                          input logic hv);
    wr(CT, c);
    wr(a, d);
    wr(CT, c | 8'h01);
    tick(3);
    chk(O_ARR_HV, hv);
    tick(5);
    wr(CT, c);
    wr(CT, 8'h00);
  endtask

  task automatic note(input string s);
    $display("test %s done: checks %0d fails %0d", s, checks, fails);
  endtask

  // ****************
  // Tests
  // ****************
  initial
  begin
    rst(12);
    rd(CT, eep_pkg::PROG_CTRL_RESET);
    wr(CT, 8'hFF);
    rd(CT, 8'hDE);
    wr(CT, 8'h03);
    rd(CT, 8'h03);
    wr(CT, 8'h01);
    rd(CT, 8'h00);
    note("control");
    for (int i = 0; i < 5; i++)
    begin
      wr(CT, sc_ctl[i]);
      tick(1);
      chk(O_ARR_SCOPE, sc_exp[i]);
      chk(O_ARR_ERASE, sc_ctl[i][2]);
    end
    wr(CT, 8'h00);
    note("scope");
    wr(CT, 8'h02);
    wr(16'h0D05, 8'h5A);
    tick(1);
    chk(O_ARR_ADDR, 10'h005);
    chk(O_ARR_WDATA, 8'h5A);
    chk(O_ARR_PROG_BUS, 1'b1);
    chk(O_ARR_SEL_SETUP, 1'b0);
    rd(16'h0D05, 8'hFF);
    wr(16'h0D06, 8'h11);
    chk(O_WR_BLOCKED, 1'b1);
    wr(CT, 8'h03);
    tick(3);
    chk(O_ARR_HV, 1'b1);
    wr(16'h0D05, 8'h00);
    chk(O_WR_BLOCKED, 1'b1);
    wr(CT, 8'h02);
    wr(CT, 8'h00);
    rd(16'h0D05, 8'h5A);
    note("program");
    hv_cycle(16'h0D03, 8'h00, 8'h0E, 1'b1);
    rd(16'h0D05, 8'hFF);
    hv_cycle(16'h0D05, 8'h5A, 8'h02, 1'b1);
    hv_cycle(16'h0D15, 8'h33, 8'h1A, 1'b1);
    hv_cycle(16'h0D05, 8'h77, 8'h16, 1'b1);
    rd(16'h0D05, 8'hFF);
    rd(16'h0D15, 8'h33);
    I_BLOCK_PROTECT = 4'h1;
    rd(16'h0D15, 8'h33);
    hv_cycle(16'h0D05, 8'h00, 8'h02, 1'b0);
    I_BLOCK_PROTECT = 4'h8;
    hv_cycle(16'h0D00, 8'h00, 8'h06, 1'b0);
    I_BLOCK_PROTECT = 4'h0;
    I_EE_PAGE = 4'h2;
    hv_cycle(16'h2FFF, 8'h00, 8'h06, 1'b1);
    rd(16'h2D15, 8'hFF);
    I_EE_PAGE = 4'h0;
    note("erase");
    rd(SU, 8'hA5);
    chk(O_SETUP_ACTIVE, 8'hA5);
    I_SETUP_PROTECT = 1'b1;
    hv_cycle(SU, 8'h00, 8'h16, 1'b0);
    I_SETUP_PROTECT = 1'b0;
    hv_cycle(SU, 8'h00, 8'h16, 1'b1);
    hv_cycle(SU, 8'h3C, 8'h02, 1'b1);
    chk(O_ARR_SEL_SETUP, 1'b1);
    rd(SU, 8'hA5);
    rst(2);
    rd(SU, 8'h3C);
    note("setup");
    I_ROM_OPTION = 1'b1;
    wr(SU, 8'hFF);
    rd(SU, 8'h3E);
    I_SPECIAL_MODE = 1'b1;
    I_MODE_BIT_A = 1'b0;
    wr(SU, 8'h00);
    rd(SU, 8'h02);
    I_SPECIAL_MODE = 1'b0;
    rst(2);
    chk(O_SETUP_ACTIVE, 8'h3E);
    note("modes");
    end_of_test();
  end

  // The tests need well under 2000 cycles; this leaves a wide margin.
  initial
  begin
    #60000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
